// >>> logic/asc_core.sv
// Behaviour
// (R1) Frame: start, data LSB first, optional parity, one or two stops.
// (R2) Output at mark when transmitter disabled, idle or in local loopback.
// (R3) Idle with empty holding register sets empty flag; a load clears it.
// (R4) Disable finishes the shifting character; transmitter reset stops at once.
// (R5) CTS gating: start only with CTS asserted; finish current character.
// (R6) Send-break drives low and ignores CTS.
// (R7) Transmitter RTS mode: negate RTS one bit after last character when disabled.
// (R8) Host asserts RTS by command before each message.
// (R9) Start bit: eight 16x samples after falling edge; a high rejects it.
// (R10) Sample each bit at its centre, LSB first, through one stop bit.
// (R11) Completed character goes to holding register; unused upper bits zero.
// (R12) Hunt at once after stop; nonzero framed-out char low half bit restarts.
// (R13) Parity, framing, overrun, break flags set at character boundary; overrun is set at the overrunning start bit instead.
// (R14) Full-character low loads zero with break; half bit high before hunting.
// (R15) Three-deep FIFO with per-entry parity, framing, break; no overrun.
// (R16) Ready when any entry, full at three; data read pops, status does not.
// (R17) Character mode shows top entry; block mode ORs entries reaching top.
// (R18) Full FIFO: char waits; another start overruns and loses the waiting one.
// (R19) Receiver RTS mode: negate on start with FIFO full, reassert when space.
// (R20) FIFO readable after disable; receiver reset clears FIFO and status.
// (R21) Loop mode changes act immediately.
// (R22) Echo: retransmit received bits, host transmit cut, flags inactive.
// (R23) Local loopback: transmitter feeds receiver, line held at mark.
// (R24) Remote loopback: retransmit, nothing stored, no error status.
// (R25) Receive and CTS inputs pass two flip-flops before use.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module asc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  input wire logic cts_n,
  output logic serial_out,
  output logic rts_n,
  output logic rx_ready_flag,
  output logic fifo_full_flag,
  output logic tx_ready_flag,
  output logic tx_empty_flag
);
  import asc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic rx_m;
    logic rx_s;
    logic cts_m;
    logic cts_s;
    logic [15:0] div_cnt;
    logic [15:0] divisor;
    logic [MODE_W-1:0] mode;
    logic rx_en;
    logic tx_en;
    logic brk;
    logic rts_on;
    logic rts_flow;
    logic [7:0] thr;
    logic thr_full;
    logic tx_empty;
    asc_tx_e tx_st;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    asc_rx_e rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_pb;
    logic [10:0] hold;
    logic hold_full;
    logic [2:0][10:0] fifo;
    logic [1:0] cnt;
    logic ovr;
    logic [2:0] acc;
    logic so;
    logic [31:0] prdata;
  } asc_state_s;

  asc_state_s s_reg;
  asc_state_s s_next;
  logic tick;
  logic txo;
  logic line;
  logic pop;
  logic wr;
  logic [1:0] loop;
  logic [2:0] stat3;
  logic host_tx;

  // Character length code to bit count
  function automatic logic [3:0] nbits(input logic [1:0] len);
    nbits = MIN_BITS + {2'h0, len};
  endfunction

  // Clear bits above the character length
  function automatic logic [7:0] trim(input logic [7:0] d, input logic [1:0] len);
    trim = d & (8'hff >> (3'h3 - {1'b0, len}));
  endfunction

  // Parity bit for data, even or odd
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction

  // ----------------------------------------
  // Bus and flag outputs
  // ----------------------------------------
  // Zero wait states keep the slave simple; prdata is captured in setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_MODE || paddr == ADDR_STATUS ||
    paddr == ADDR_CMD || paddr == ADDR_DATA || paddr == ADDR_DIV);
  assign prdata = s_reg.prdata;
  assign serial_out = s_reg.so;
  assign rts_n = !s_reg.rts_on;
  assign loop = s_reg.mode[M_LOOP_HI:M_LOOP_LO];
  // (R22) Echo and remote cut the host transmit path
  assign host_tx = (loop == LOOP_NORMAL) || (loop == LOOP_LOCAL);
  // (R16) FIFO occupancy flags
  assign rx_ready_flag = (s_reg.cnt != 2'h0);
  assign fifo_full_flag = (s_reg.cnt == FIFO_DEPTH);
  assign tx_ready_flag = s_reg.tx_en && !s_reg.thr_full && host_tx;
  assign tx_empty_flag = s_reg.tx_empty && host_tx;
  // (R17) Status source chosen by error mode
  assign stat3 = s_reg.mode[M_BLOCK] ? s_reg.acc :
    (rx_ready_flag ? s_reg.fifo[0][E_STAT_HI:E_STAT_LO] : 3'h0);
  assign wr = psel && penable && pwrite;
  assign pop = psel && penable && !pwrite && (paddr == ADDR_DATA);
  assign tick = (s_reg.div_cnt == 16'h0000);

  // (R1) Transmit bit for the current state; break forces space
  // (R6) Break drives low whatever CTS does
  always_comb begin
    case (s_reg.tx_st)
      TX_START: txo = 1'b0;
      TX_DATA: txo = s_reg.tx_sh[0];
      TX_PAR: txo = s_reg.tx_par;
      default: txo = 1'b1;
    endcase
    if (s_reg.brk) begin
      txo = 1'b0;
    end
  end

  // (R23) Local loopback feeds the receiver from the transmitter
  assign line = (loop == LOOP_LOCAL) ? txo : s_reg.rx_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] c;
    logic pe;
    logic brkc;
    c = s_reg.cnt;
    pe = 1'b0;
    brkc = 1'b0;
    s_next = s_reg;
    // (R25) Two-stage synchronisers on line and CTS
    s_next.rx_m = serial_in;
    s_next.rx_s = s_reg.rx_m;
    s_next.cts_m = cts_n;
    s_next.cts_s = s_reg.cts_m;
    // 16x tick divider; the divisor is software-set
    s_next.div_cnt = tick ? s_reg.divisor : s_reg.div_cnt - 16'h0001;
    // (R2) Mark in local loopback; idle or disabled transmitter shows mark
    // (R21) Output path follows the loop mode at once
    if (loop == LOOP_ECHO || loop == LOOP_REMOTE) begin
      s_next.so = s_reg.rx_s;
    end else if (loop == LOOP_LOCAL) begin
      s_next.so = 1'b1;
    end else begin
      s_next.so = txo;
    end
    // Read data is captured in the setup phase
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_MODE: s_next.prdata = {21'h0, s_reg.mode};
        ADDR_STATUS: s_next.prdata = {24'h0, stat3[2], stat3[1], stat3[0], s_reg.ovr,
          tx_empty_flag, tx_ready_flag, fifo_full_flag, rx_ready_flag};
        ADDR_DATA: s_next.prdata = {24'h0, s_reg.fifo[0][7:0]};
        ADDR_DIV: s_next.prdata = {16'h0, s_reg.divisor};
        default: s_next.prdata = 32'h0;
      endcase
    end
    // Register writes and simple commands
    if (wr && paddr == ADDR_MODE) begin
      s_next.mode = pwdata[MODE_W-1:0];
    end
    if (wr && paddr == ADDR_DIV) begin
      s_next.divisor = pwdata[15:0];
    end
    if (wr && paddr == ADDR_CMD) begin
      if (pwdata[C_RX_EN]) s_next.rx_en = 1'b1;
      if (pwdata[C_RX_DIS]) s_next.rx_en = 1'b0;
      if (pwdata[C_TX_EN]) s_next.tx_en = 1'b1;
      // (R4) Disable only stops new starts; the shifter finishes
      if (pwdata[C_TX_DIS]) s_next.tx_en = 1'b0;
      if (pwdata[C_BRK_ON]) s_next.brk = 1'b1;
      if (pwdata[C_BRK_OFF]) s_next.brk = 1'b0;
      // (R8) Host asserts RTS by command before a message
      if (pwdata[C_RTS_ON]) begin
        s_next.rts_on = 1'b1;
        s_next.rts_flow = 1'b0;
      end
      if (pwdata[C_RTS_OFF]) s_next.rts_on = 1'b0;
      // Cleared here so a same-cycle overrun below still wins
      if (pwdata[C_ERR_RST]) begin
        s_next.ovr = 1'b0;
        s_next.acc = 3'h0;
      end
    end
    // (R16) Data read pops the top entry and its status
    if (pop && c != 2'h0) begin
      s_next.fifo[0] = s_reg.fifo[1];
      s_next.fifo[1] = s_reg.fifo[2];
      c = c - 2'h1;
      // (R17) Block mode ORs each entry that reaches the top
      if (c != 2'h0) s_next.acc = s_next.acc | s_reg.fifo[1][E_STAT_HI:E_STAT_LO];
    end
    // (R15) Shift register output moves into the first free slot
    if (s_reg.hold_full && c != FIFO_DEPTH) begin
      s_next.fifo[c] = s_reg.hold;
      if (c == 2'h0) s_next.acc = s_next.acc | s_reg.hold[E_STAT_HI:E_STAT_LO];
      c = c + 2'h1;
      s_next.hold_full = 1'b0;
    end
    s_next.cnt = c;
    // (R19) Reassert RTS once a slot is free
    if (s_reg.rts_flow && c != FIFO_DEPTH) begin
      s_next.rts_on = 1'b1;
      s_next.rts_flow = 1'b0;
    end
    // (R3) A buffer load clears empty and restarts the transmitter
    if (wr && paddr == ADDR_DATA && tx_ready_flag) begin
      s_next.thr = pwdata[7:0];
      s_next.thr_full = 1'b1;
      s_next.tx_empty = 1'b0;
    end
    // Transmitter, one bit per sixteen ticks
    if (tick) begin
      s_next.tx_sub = s_reg.tx_sub + 4'h1;
      case (s_reg.tx_st)
        TX_IDLE: begin
          s_next.tx_sub = 4'h0;
          // (R5) Start only with CTS asserted when gating is on
          if (s_reg.tx_en && s_reg.thr_full && !s_reg.brk && host_tx &&
              (!s_reg.mode[M_CTSEN] || !s_reg.cts_s)) begin
            s_next.tx_sh = trim(s_reg.thr, s_reg.mode[M_LEN_HI:M_LEN_LO]);
            s_next.tx_par = par_of(trim(s_reg.thr, s_reg.mode[M_LEN_HI:M_LEN_LO]),
              s_reg.mode[M_PODD]);
            s_next.thr_full = 1'b0;
            s_next.tx_st = TX_START;
          end
        end
        default: begin
          if (s_reg.tx_sub == SUB_LAST) begin
            case (s_reg.tx_st)
              TX_START: begin
                s_next.tx_st = TX_DATA;
                s_next.tx_bit = 4'h0;
              end
              // (R1) LSB first, then optional parity
              TX_DATA: begin
                s_next.tx_sh = s_reg.tx_sh >> 1;
                s_next.tx_bit = s_reg.tx_bit + 4'h1;
                if (s_reg.tx_bit == nbits(s_reg.mode[M_LEN_HI:M_LEN_LO]) - 4'h1) begin
                  s_next.tx_st = s_reg.mode[M_PEN] ? TX_PAR : TX_STOP;
                  s_next.tx_bit = 4'h0;
                end
              end
              TX_PAR: s_next.tx_st = TX_STOP;
              TX_STOP: begin
                s_next.tx_bit = s_reg.tx_bit + 4'h1;
                if (s_reg.tx_bit == {3'h0, s_reg.mode[M_STOP2]}) begin
                  // (R3) Empty when nothing waits; a load in this same cycle wins
                  s_next.tx_empty = !s_next.thr_full;
                  // (R7) One more bit time, then RTS drops
                  s_next.tx_st = (s_reg.mode[M_TXRTS] && !s_reg.tx_en) ? TX_RTSW : TX_IDLE;
                end
              end
              TX_RTSW: begin
                // (R7) Negate RTS one bit after the last stop
                s_next.rts_on = 1'b0;
                s_next.tx_st = TX_IDLE;
              end
              default: s_next.tx_st = TX_IDLE;
            endcase
          end
        end
      endcase
    end
    // Receiver
    if (tick) begin
      s_next.rx_sub = s_reg.rx_sub + 4'h1;
      case (s_reg.rx_st)
        // (R9) First low sample opens the start-bit check
        RX_HUNT: begin
          s_next.rx_sub = 4'h0;
          if (s_reg.rx_en && !line) s_next.rx_st = RX_START;
        end
        RX_START: begin
          // (R9) Any high sample rejects the start bit
          if (line) begin
            s_next.rx_st = RX_HUNT;
          end else if (s_reg.rx_sub == START_LAST) begin
            s_next.rx_st = RX_DATA;
            s_next.rx_sub = 4'h0;
            s_next.rx_bit = 4'h0;
            s_next.rx_sh = 8'h00;
            s_next.rx_pb = 1'b0;
            // (R18) Overrun flagged at the overrunning start bit
            if (s_reg.hold_full && s_reg.cnt == FIFO_DEPTH) s_next.ovr = 1'b1;
            // (R19) Negate RTS on a start with the FIFO full
            if (s_reg.mode[M_RXRTS] && s_reg.cnt == FIFO_DEPTH) begin
              s_next.rts_on = 1'b0;
              s_next.rts_flow = 1'b1;
            end
          end
        end
        RX_DATA: begin
          // (R10) Centre sampling, LSB first; (R11) upper bits stay zero
          if (s_reg.rx_sub == SUB_LAST) begin
            s_next.rx_sh[s_reg.rx_bit[2:0]] = line;
            s_next.rx_bit = s_reg.rx_bit + 4'h1;
            if (s_reg.rx_bit == nbits(s_reg.mode[M_LEN_HI:M_LEN_LO]) - 4'h1) begin
              s_next.rx_st = s_reg.mode[M_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (s_reg.rx_sub == SUB_LAST) begin
            s_next.rx_pb = line;
            s_next.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s_reg.rx_sub == SUB_LAST) begin
            s_next.rx_sub = 4'h0;
            // (R13) Flags fixed at the character boundary
            pe = s_reg.mode[M_PEN] && (s_reg.rx_pb != par_of(s_reg.rx_sh, s_reg.mode[M_PODD]));
            // (R14) Whole character low including stop is a break
            brkc = !line && s_reg.rx_sh == 8'h00 && !s_reg.rx_pb;
            // (R24) Remote loopback stores nothing and reports no errors
            if (loop != LOOP_REMOTE) begin
              // (R18) A waiting character is overwritten and lost
              s_next.hold = {brkc, !line, pe && !brkc, brkc ? 8'h00 : s_reg.rx_sh};
              s_next.hold_full = 1'b1;
            end
            // (R12) Hunt at once; nonzero framing error may restart
            if (line) begin
              s_next.rx_st = RX_HUNT;
            end else if (brkc) begin
              s_next.rx_st = RX_BRKW;
            end else begin
              s_next.rx_st = (s_reg.rx_sh != 8'h00) ? RX_START : RX_HUNT;
            end
          end
        end
        RX_BRKW: begin
          // (R14) Half a bit of mark before hunting again
          if (!line) begin
            s_next.rx_sub = 4'h0;
          end else if (s_reg.rx_sub == START_LAST + 4'h1) begin
            s_next.rx_st = RX_HUNT;
          end
        end
        default: s_next.rx_st = RX_HUNT;
      endcase
    end
    // (R20) Receiver reset clears FIFO, status and flow state
    if (wr && paddr == ADDR_CMD && pwdata[C_RX_RST]) begin
      s_next.rx_en = 1'b0;
      s_next.cnt = 2'h0;
      s_next.hold_full = 1'b0;
      s_next.ovr = 1'b0;
      s_next.acc = 3'h0;
      s_next.rx_st = RX_HUNT;
      if (s_reg.rts_flow) s_next.rts_on = 1'b1;
      s_next.rts_flow = 1'b0;
    end
    // (R4) Transmitter reset stops immediately
    if (wr && paddr == ADDR_CMD && pwdata[C_TX_RST]) begin
      s_next.tx_en = 1'b0;
      s_next.thr_full = 1'b0;
      s_next.brk = 1'b0;
      s_next.tx_empty = 1'b1;
      s_next.tx_st = TX_IDLE;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.divisor <= DIV_RST;
      s_reg.tx_empty <= 1'b1;
      s_reg.so <= 1'b1;
      s_reg.rx_m <= 1'b1;
      s_reg.rx_s <= 1'b1;
      s_reg.cts_m <= 1'b1;
      s_reg.cts_s <= 1'b1;
      s_reg.tx_st <= TX_IDLE;
      s_reg.rx_st <= RX_HUNT;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_break_space: assert property (s_reg.brk && loop == LOOP_NORMAL |=> !serial_out) // (R6)
    else $error("break did not drive space");
  a_local_mark: assert property (loop == LOOP_LOCAL |=> serial_out) // (R23)
    else $error("local loopback line not at mark");
  a_push_ready: assert property (s_reg.hold_full && !rx_ready_flag |=> rx_ready_flag) // (R16)
    else $error("ready not set after push");
  a_pop_full: assert property (pop && fifo_full_flag && !s_reg.hold_full |=> !fifo_full_flag) // (R16)
    else $error("full not cleared by pop");
  a_status_keep: assert property (psel && penable && !pwrite && paddr == ADDR_STATUS // (R16)
    && !s_reg.hold_full |=> s_reg.cnt == $past(s_reg.cnt))
    else $error("status read changed fifo");
  // Any character length: nothing above the top data bit survives
  a_short_upper: assert property ($rose(rx_ready_flag) // (R11)
    |-> (s_reg.fifo[0][7:0] >> nbits(s_reg.mode[M_LEN_HI:M_LEN_LO])) == 8'h00)
    else $error("unused upper bits not zero");
  a_thr_empty: assert property (wr && paddr == ADDR_DATA && tx_ready_flag // (R3)
    |=> !s_reg.tx_empty ##1 (s_reg.thr_full || s_reg.tx_st != TX_IDLE))
    else $error("buffer load did not clear empty");
  a_flow_rts: assert property (tick && s_reg.rx_st == RX_START // (R19)
    && s_reg.rx_sub == START_LAST && !line && s_reg.mode[M_RXRTS] && fifo_full_flag |=> rts_n)
    else $error("rts not negated on full");
  a_remote_store: assert property (loop == LOOP_REMOTE && !s_reg.hold_full // (R24)
    |=> !$rose(s_reg.hold_full))
    else $error("remote loopback stored data");
  a_cts_hold: assert property (s_reg.mode[M_CTSEN] && s_reg.cts_s // (R5)
    && s_reg.tx_st == TX_IDLE |=> s_reg.tx_st == TX_IDLE)
    else $error("started without clear to send");
  a_overrun_set: assert property (tick && s_reg.rx_st == RX_START // (R18)
    && s_reg.rx_sub == START_LAST && !line && s_reg.hold_full && fifo_full_flag |=> s_reg.ovr)
    else $error("overrun not flagged");

  c_fifo_full: cover property (fifo_full_flag ##1 pop);
  c_break_rx: cover property (s_reg.rx_st == RX_BRKW);
  c_rts_drop: cover property (s_reg.tx_st == TX_RTSW ##[1:40] !s_reg.rts_on);
  c_overrun: cover property ($rose(s_reg.ovr));
endmodule // asc_core

// >>> logic/asc_pkg.sv
package asc_pkg;
  // ----------------------------------------
  // Register map, one aligned word each
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_DIV = 8'h10;
  // Mode register fields
  localparam int M_LEN_LO = 0;
  localparam int M_LEN_HI = 1;
  localparam int M_PEN = 2;
  localparam int M_PODD = 3;
  localparam int M_STOP2 = 4;
  localparam int M_BLOCK = 5;
  localparam int M_RXRTS = 6;
  localparam int M_TXRTS = 7;
  localparam int M_CTSEN = 8;
  localparam int M_LOOP_LO = 9;
  localparam int M_LOOP_HI = 10;
  localparam int MODE_W = 11;
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_ECHO = 2'h1;
  localparam logic [1:0] LOOP_LOCAL = 2'h2;
  localparam logic [1:0] LOOP_REMOTE = 2'h3;
  // Command register bits, one action per bit
  localparam int C_RX_EN = 0;
  localparam int C_RX_DIS = 1;
  localparam int C_TX_EN = 2;
  localparam int C_TX_DIS = 3;
  localparam int C_RX_RST = 4;
  localparam int C_TX_RST = 5;
  localparam int C_ERR_RST = 6;
  localparam int C_BRK_ON = 7;
  localparam int C_BRK_OFF = 8;
  localparam int C_RTS_ON = 9;
  localparam int C_RTS_OFF = 10;
  // FIFO entry: data then parity, framing, break
  localparam int E_STAT_LO = 8;
  localparam int E_STAT_HI = 10;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  // Timing in 16x ticks
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] START_LAST = 4'h6;
  localparam logic [3:0] MIN_BITS = 4'h5;
  localparam logic [15:0] DIV_RST = 16'h0036;
  typedef enum logic [5:0] {TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
    TX_PAR = 6'h08, TX_STOP = 6'h10, TX_RTSW = 6'h20} asc_tx_e;
  typedef enum logic [5:0] {RX_HUNT = 6'h01, RX_START = 6'h02, RX_DATA = 6'h04,
    RX_PAR = 6'h08, RX_STOP = 6'h10, RX_BRKW = 6'h20} asc_rx_e;
endpackage

// >>> verif/asc_remote.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote serial device on the line side
// ----------------------------------------
module asc_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] rx_byte;
  logic rx_stop;
  int rx_count;
  // Line idles at mark, as a pulled-up link would
  initial begin
    line_out = 1'b1;
    rx_byte = 8'h00;
    rx_stop = 1'b0;
    rx_count = 0;
  end
  // frame order
  // Sender: start, data LSB first, even parity (optionally spoiled), one stop
  task automatic send(input logic [7:0] d, input int nb, input logic par, input logic bad);
    logic p;
    p = bad;
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int k = 0; k < nb; k++) begin
      line_out <= d[k];
      p = p ^ d[k];
      repeat (BIT_CLKS) @(posedge clk);
    end
    if (par) begin
      line_out <= p;
      repeat (BIT_CLKS) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  // Break: hold space for whole bit times, then mark for one bit
  task automatic hold_low(input int nbits);
    line_out <= 1'b0;
    repeat (BIT_CLKS * nbits) @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  // frame order
  // Receiver: samples at bit centres, eight data bits LSB first, then the stop bit
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT_CLKS) @(posedge clk);
      rx_byte[k] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk);
    rx_stop = line_in;
    rx_count++;
  end
endmodule // asc_remote

// >>> verif/asc_core_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module asc_core_tb;
  import asc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cts_n = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_in, serial_out, rts_n;
  logic rx_ready_flag, fifo_full_flag, tx_ready_flag, tx_empty_flag;
  logic [31:0] rd;
  logic err;
  logic [7:0] chars [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  int bad_count = 0;
  int checks_done = 0;
  always #5 pclk = ~pclk;
  asc_core asc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in(serial_in), .cts_n(cts_n), .serial_out(serial_out),
    .rts_n(rts_n), .rx_ready_flag(rx_ready_flag), .fifo_full_flag(fifo_full_flag),
    .tx_ready_flag(tx_ready_flag), .tx_empty_flag(tx_empty_flag));
  asc_remote asc_remote_i (.clk(pclk), .line_in(serial_out), .line_out(serial_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One APB transfer; the wait on pready is bounded so a dead slave ends the run
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait until the remote side has taken k characters in total
  task automatic wait_tx(input int k);
    int n;
    for (n = 0; n < 1000 && asc_remote_i.rx_count < k; n++) @(posedge pclk);
    if (n == 1000) begin
      bad_count++;
      final_report();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("idle line", 1'b1, serial_out)
    apb(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("status at reset", 32'h0000_0008, rd)
    apb(8'h20, 1'b0, 32'h0);
    `CHK("unmapped error", 1'b1, err)
  endtask
  task automatic t_tx();
    apb(ADDR_DIV, 1'b1, 32'h0);
    apb(ADDR_MODE, 1'b1, 32'h003);
    apb(ADDR_CMD, 1'b1, 32'h005);
    apb(ADDR_DATA, 1'b1, 32'ha5);
    repeat (2) @(posedge pclk);
    `CHK("empty cleared", 1'b0, tx_empty_flag)
    wait_tx(1);
    `CHK("first char", 8'ha5, asc_remote_i.rx_byte)
    `CHK("stop bit", 1'b1, asc_remote_i.rx_stop)
    // A load into a full holding register is dropped, so wait for the first frame
    apb(ADDR_DATA, 1'b1, 32'h3c);
    wait_tx(2);
    `CHK("second char", 8'h3c, asc_remote_i.rx_byte)
    repeat (40) @(posedge pclk);
    `CHK("empty again", 1'b1, tx_empty_flag)
    `CHK("mark when idle", 1'b1, serial_out)
  endtask
  task automatic t_rx();
    apb(ADDR_MODE, 1'b1, 32'h043);
    apb(ADDR_CMD, 1'b1, 32'h201);
    @(posedge pclk);
    `CHK("rts asserted", 1'b0, rts_n)
    for (int k = 0; k < 5; k++) asc_remote_i.send(chars[k], 8, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    `CHK("fifo full", 1'b1, fifo_full_flag)
    `CHK("flow negated", 1'b1, rts_n)
    apb(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("overrun", 1'b1, rd[4])
    for (int k = 0; k < 4; k++) begin
      apb(ADDR_DATA, 1'b0, 32'h0);
      `CHK("fifo order", {24'h0, chars[k == 3 ? 4 : k]}, rd)
      repeat (4) @(posedge pclk);
    end
    `CHK("fifo drained", 1'b0, rx_ready_flag)
    `CHK("flow reasserted", 1'b0, rts_n)
  endtask
  task automatic t_err();
    apb(ADDR_MODE, 1'b1, 32'h006);
    apb(ADDR_CMD, 1'b1, 32'h040);
    asc_remote_i.send(8'h7f, 7, 1'b1, 1'b1);
    asc_remote_i.hold_low(12);
    repeat (8) @(posedge pclk);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("top parity", 2'b01, {rd[7], rd[5]})
    apb(ADDR_DATA, 1'b0, 32'h0);
    `CHK("short char", 32'h7f, rd)
    repeat (4) @(posedge pclk);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    `CHK("break status", 2'b10, {rd[7], rd[5]})
    apb(ADDR_DATA, 1'b0, 32'h0);
    `CHK("break char", 32'h0, rd)
  endtask
  task automatic t_cts();
    apb(ADDR_MODE, 1'b1, 32'h103);
    cts_n <= 1'b1;
    apb(ADDR_DATA, 1'b1, 32'h5a);
    repeat (200) @(posedge pclk);
    `CHK("held by cts", 2, asc_remote_i.rx_count)
    cts_n <= 1'b0;
    wait_tx(3);
    `CHK("released char", 8'h5a, asc_remote_i.rx_byte)
  endtask
  // Remote loopback, then echo, then receiver reset
  task automatic t_loop();
    apb(ADDR_MODE, 1'b1, 32'h603);
    asc_remote_i.send(8'h69, 8, 1'b0, 1'b0);
    `CHK("remote echo", 8'h69, asc_remote_i.rx_byte)
    `CHK("remote count", 4, asc_remote_i.rx_count)
    `CHK("remote not stored", 1'b0, rx_ready_flag)
    apb(ADDR_MODE, 1'b1, 32'h203);
    `CHK("echo tx flags", 2'b00, {tx_ready_flag, tx_empty_flag})
    asc_remote_i.send(8'h96, 8, 1'b0, 1'b0);
    `CHK("echo char", 8'h96, asc_remote_i.rx_byte)
    `CHK("echo stored", 1'b1, rx_ready_flag)
    apb(ADDR_CMD, 1'b1, 32'h010);
    @(posedge pclk);
    `CHK("rx reset clears", 1'b0, rx_ready_flag)
  endtask
  // Disable right after the load; RTS must drop a bit after the last stop
  task automatic t_txrts();
    apb(ADDR_MODE, 1'b1, 32'h083);
    // RTS asserted by hand before the message
    apb(ADDR_CMD, 1'b1, 32'h204);
    apb(ADDR_DATA, 1'b1, 32'hc3);
    apb(ADDR_CMD, 1'b1, 32'h008);
    wait_tx(6);
    `CHK("disabled char finished", 8'hc3, asc_remote_i.rx_byte)
    `CHK("rts held to last stop", 1'b0, rts_n)
    repeat (40) @(posedge pclk);
    `CHK("rts dropped", 1'b1, rts_n)
  endtask
  task automatic t_brk();
    apb(ADDR_MODE, 1'b1, 32'h103);
    cts_n <= 1'b1;
    apb(ADDR_CMD, 1'b1, 32'h080);
    repeat (2) @(posedge pclk);
    `CHK("break low without cts", 1'b0, serial_out)
    apb(ADDR_CMD, 1'b1, 32'h100);
    repeat (2) @(posedge pclk);
    `CHK("mark after break", 1'b1, serial_out)
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_cts();
    t_loop();
    t_txrts();
    t_brk();
    final_report();
  end
endmodule // asc_core_tb
